/* File: design/ccpu_pkg.sv */
package ccpu_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [5:0] UNIT1_VALUE_LOW_IDX = 6'h15;
  localparam logic [5:0] UNIT1_VALUE_HIGH_IDX = 6'h16;
  localparam logic [5:0] UNIT1_CONTROL_IDX = 6'h17;
  localparam logic [5:0] UNIT2_VALUE_LOW_IDX = 6'h1b;
  localparam logic [5:0] UNIT2_VALUE_HIGH_IDX = 6'h1c;
  localparam logic [5:0] UNIT2_CONTROL_IDX = 6'h1d;
  localparam logic [5:0] EVENT_FLAGS_IDX = 6'h0c;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_MSB = 3;
  localparam int CTRL_DUTY_LSB = 4;
  localparam int CTRL_DUTY_MSB = 5;

  // upper two bits of the mode field pick the function
  localparam logic [1:0] GROUP_OFF = 2'h0;
  localparam logic [1:0] GROUP_CAPTURE = 2'h1;
  localparam logic [1:0] GROUP_COMPARE = 2'h2;
  localparam logic [1:0] GROUP_PWM = 2'h3;

  // lower two bits of the mode field within capture and compare
  localparam logic [1:0] CAP_FALL = 2'h0;
  localparam logic [1:0] CAP_RISE = 2'h1;
  localparam logic [1:0] CAP_RISE4 = 2'h2;
  localparam logic [1:0] CAP_RISE16 = 2'h3;
  localparam logic [1:0] CMP_SET = 2'h0;
  localparam logic [1:0] CMP_CLEAR = 2'h1;
  localparam logic [1:0] CMP_SOFT = 2'h2;
  localparam logic [1:0] CMP_TRIGGER = 2'h3;

  // prescaler terminal counts
  localparam logic [3:0] PRESC_LAST4 = 4'h3;
  localparam logic [3:0] PRESC_LAST16 = 4'hf;

  // reset values
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [7:0] VALUE_RESET = 8'h00;

  typedef struct packed {
    logic [5:0] ctrl;
    logic [7:0] val_lo;
    logic [7:0] val_hi;
    logic [1:0] duty_lat;
    logic [3:0] presc;
    logic out;
    logic flag;
  } ccpu_unit_s;

  typedef struct packed {
    ccpu_unit_s [1:0] unit;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic [7:0] prdata;
    logic slverr;
    logic wclr;
    logic adc;
  } ccpu_state_s;

endpackage

/* File: design/ccpu_top.sv */
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module ccpu_top
  import ccpu_pkg::*;
#(
  parameter int UNITS = 2,
  parameter int ADDR_WIDTH = 8
)
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_WIDTH-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // shared wide timer
  input wire logic [15:0] WIDE_TIMER_COUNT,
  output logic WIDE_TIMER_CLEAR,
  // converter trigger, second unit only
  input wire logic ADC_ENABLE,
  output logic ADC_START,
  // shared period timer
  input wire logic [7:0] PERIOD_TIMER_COUNT,
  input wire logic [7:0] PERIOD_VALUE,
  input wire logic PERIOD_INCREMENT,
  input wire logic [1:0] PERIOD_PHASE,
  output logic PERIOD_TIMER_CLEAR,
  // unit pins and flags
  input wire logic [1:0] UNIT_PIN,
  output logic [1:0] UNIT_OUT,
  output logic [1:0] UNIT_EVENT_FLAG
);

  if (UNITS != 2)
  begin : g_units_check
    $error("ccpu_top serves exactly two units");
  end
  if (ADDR_WIDTH < 8)
  begin : g_addr_check
    $error("ccpu_top needs at least 8 address bits");
  end

  ccpu_state_s st;
  ccpu_state_s next_st;

  logic wr;
  logic rollover;
  logic [5:0] idx;
  logic aligned;

  assign wr = PSEL & PENABLE & PWRITE;
  assign idx = PADDR[7:2];
  // a shift instead of a part-select keeps the default 8-bit width legal
  assign aligned = (PADDR[1:0] == 2'h0) && ((PADDR >> 8) == '0);
  // period end is judged once per period-timer increment
  assign rollover = PERIOD_INCREMENT && (PERIOD_TIMER_COUNT == PERIOD_VALUE);

  always_comb
  begin
    logic [3:0] mode;
    logic rise;
    logic fall;
    logic ev;
    logic match;
    logic any_pwm;
    logic [5:0] lo_idx;
    logic [5:0] hi_idx;
    logic [5:0] ct_idx;
    mode = 4'h0;
    rise = 1'b0;
    fall = 1'b0;
    ev = 1'b0;
    match = 1'b0;
    any_pwm = 1'b0;
    lo_idx = 6'h0;
    hi_idx = 6'h0;
    ct_idx = 6'h0;
    next_st = st;
    next_st.wclr = 1'b0;
    next_st.adc = 1'b0;
    // pin level passes two flops; the first is read only by the second
    next_st.sync1 = UNIT_PIN;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;

    for (int u = 0; u < 2; u++)
    begin
      mode = st.unit[u].ctrl[CTRL_MODE_MSB:CTRL_MODE_LSB];
      lo_idx = (u == 0) ? UNIT1_VALUE_LOW_IDX : UNIT2_VALUE_LOW_IDX;
      hi_idx = (u == 0) ? UNIT1_VALUE_HIGH_IDX : UNIT2_VALUE_HIGH_IDX;
      ct_idx = (u == 0) ? UNIT1_CONTROL_IDX : UNIT2_CONTROL_IDX;
      rise = st.sync2[u] & ~st.prev[u];
      fall = ~st.sync2[u] & st.prev[u];

      // software writes; hardware updates below take precedence
      if (wr && aligned && idx == ct_idx)
      begin
        next_st.unit[u].ctrl = PWDATA[5:0];
      end
      if (wr && aligned && idx == lo_idx)
      begin
        next_st.unit[u].val_lo = PWDATA[7:0];
      end
      // high byte is the duty shadow in pwm and cannot be written there
      if (wr && aligned && idx == hi_idx && mode[3:2] != GROUP_PWM)
      begin
        next_st.unit[u].val_hi = PWDATA[7:0];
      end
      if (wr && aligned && idx == EVENT_FLAGS_IDX && PWDATA[u])
      begin
        next_st.unit[u].flag = 1'b0;
      end

      unique case (mode[3:2])
        GROUP_CAPTURE:
        begin
          // counter survives a direct change between prescale settings
          if (rise)
          begin
            next_st.unit[u].presc = st.unit[u].presc + 4'h1;
          end
          unique case (mode[1:0])
            CAP_FALL: ev = fall;
            CAP_RISE: ev = rise;
            CAP_RISE4: ev = rise && (st.unit[u].presc[1:0] == PRESC_LAST4[1:0]);
            CAP_RISE16: ev = rise && (st.unit[u].presc == PRESC_LAST16);
          endcase
          if (ev)
          begin
            // overwrite even when the last value was never read
            next_st.unit[u].val_lo = WIDE_TIMER_COUNT[7:0];
            next_st.unit[u].val_hi = WIDE_TIMER_COUNT[15:8];
            next_st.unit[u].flag = 1'b1;
          end
        end
        GROUP_COMPARE:
        begin
          next_st.unit[u].presc = 4'h0;
          match = {st.unit[u].val_hi, st.unit[u].val_lo} == WIDE_TIMER_COUNT;
          if (match)
          begin
            next_st.unit[u].flag = 1'b1;
            unique case (mode[1:0])
              CMP_SET: next_st.unit[u].out = 1'b1;
              CMP_CLEAR: next_st.unit[u].out = 1'b0;
              CMP_SOFT: next_st.unit[u].out = st.unit[u].out;
              CMP_TRIGGER:
              begin
                next_st.wclr = 1'b1;
                if (u == 1 && ADC_ENABLE)
                begin
                  next_st.adc = 1'b1;
                end
              end
            endcase
          end
        end
        GROUP_PWM:
        begin
          any_pwm = 1'b1;
          next_st.unit[u].presc = 4'h0;
          // duty beyond the period never matches, so the pin stays high
          if ({st.unit[u].val_hi, st.unit[u].duty_lat} ==
              {PERIOD_TIMER_COUNT, PERIOD_PHASE})
          begin
            next_st.unit[u].out = 1'b0;
          end
          if (rollover)
          begin
            next_st.unit[u].val_hi = st.unit[u].val_lo;
            next_st.unit[u].duty_lat = st.unit[u].ctrl[CTRL_DUTY_MSB:CTRL_DUTY_LSB];
            next_st.unit[u].out = ({st.unit[u].val_lo,
                                    st.unit[u].ctrl[CTRL_DUTY_MSB:CTRL_DUTY_LSB]} != 10'h000);
          end
        end
        GROUP_OFF:
        begin
          // 0000 and the undefined 0001..0011 all behave as off
          next_st.unit[u].presc = 4'h0;
          next_st.unit[u].out = 1'b0;
          next_st.unit[u].duty_lat = 2'h0;
        end
      endcase
    end

    // read data is captured in the setup cycle and shown in the access cycle
    if (PSEL && !PENABLE)
    begin
      next_st.slverr = 1'b0;
      next_st.prdata = 8'h00;
      if (!aligned)
      begin
        next_st.slverr = 1'b1;
      end
      else
      begin
        unique case (idx)
          UNIT1_VALUE_LOW_IDX: next_st.prdata = st.unit[0].val_lo;
          UNIT1_VALUE_HIGH_IDX: next_st.prdata = st.unit[0].val_hi;
          UNIT1_CONTROL_IDX: next_st.prdata = {2'h0, st.unit[0].ctrl};
          UNIT2_VALUE_LOW_IDX: next_st.prdata = st.unit[1].val_lo;
          UNIT2_VALUE_HIGH_IDX: next_st.prdata = st.unit[1].val_hi;
          UNIT2_CONTROL_IDX: next_st.prdata = {2'h0, st.unit[1].ctrl};
          EVENT_FLAGS_IDX: next_st.prdata = {6'h00, st.unit[1].flag, st.unit[0].flag};
          default: next_st.slverr = 1'b1;
        endcase
      end
    end
    PERIOD_TIMER_CLEAR = rollover && any_pwm;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      for (int u = 0; u < 2; u++)
      begin
        st.unit[u].ctrl <= CTRL_RESET;
        st.unit[u].val_lo <= VALUE_RESET;
        st.unit[u].val_hi <= VALUE_RESET;
        st.unit[u].duty_lat <= 2'h0;
        st.unit[u].presc <= 4'h0;
        st.unit[u].out <= 1'b0;
        st.unit[u].flag <= 1'b0;
      end
      st.sync1 <= 2'h0;
      st.sync2 <= 2'h0;
      st.prev <= 2'h0;
      st.prdata <= 8'h00;
      st.slverr <= 1'b0;
      st.wclr <= 1'b0;
      st.adc <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // zero wait states: the answer is ready in the first access cycle
  assign PREADY = 1'b1;
  assign PRDATA = {24'h000000, st.prdata};
  assign PSLVERR = st.slverr & PSEL & PENABLE;
  assign WIDE_TIMER_CLEAR = st.wclr;
  assign ADC_START = st.adc;
  assign UNIT_OUT = {st.unit[1].out, st.unit[0].out};
  assign UNIT_EVENT_FLAG = {st.unit[1].flag, st.unit[0].flag};

endmodule // ccpu_top

`default_nettype wire

/* File: test/ccpu_pin_src.sv */
`timescale 1ns/1ns
`default_nettype none
module ccpu_pin_src
  import ccpu_pkg::*;
(
  // clock and pins
  input wire logic clk,
  output logic [1:0] pin
);
  // a driven source: holds its level between pulses, never floats
  initial pin = 2'h0;
  task automatic edges(input int u, input int n);
    repeat (n)
    begin
      @(posedge clk);
      pin[u] <= 1'b1;
      repeat (3) @(posedge clk);
      pin[u] <= 1'b0;
      repeat (3) @(posedge clk);
    end
    // covers the synchroniser and edge latency
    repeat (4) @(posedge clk);
  endtask
endmodule // ccpu_pin_src
`default_nettype wire

/* File: test/ccpu_props.sv */
`timescale 1ns/1ns
`default_nettype none
module ccpu_props
  import ccpu_pkg::*;
(
  // clock, reset and bus
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  // timers, outputs, flags
  input wire logic WIDE_TIMER_CLEAR,
  input wire logic ADC_ENABLE,
  input wire logic ADC_START,
  input wire logic [7:0] PERIOD_TIMER_COUNT,
  input wire logic [7:0] PERIOD_VALUE,
  input wire logic PERIOD_INCREMENT,
  input wire logic PERIOD_TIMER_CLEAR,
  input wire logic [1:0] UNIT_OUT,
  input wire logic [1:0] UNIT_EVENT_FLAG
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  wire logic acc = PSEL && PENABLE;
  wire logic c1 = PADDR == {UNIT1_CONTROL_IDX, 2'h0};
  wire logic c2 = PADDR == {UNIT2_CONTROL_IDX, 2'h0};
  sequence s_off1;
    acc && PWRITE && c1 && PWDATA[3:2] == 2'h0;
  endsequence
  sequence s_clr1;
    acc && PWRITE && PADDR == {EVENT_FLAGS_IDX, 2'h0} && PWDATA[0];
  endsequence
  property p_rdhi;
    acc && !PWRITE |-> PRDATA[31:8] == 24'h0;
  endproperty
  property p_ready;
    acc |-> PREADY;
  endproperty
  property p_rsvd;
    acc && !PWRITE && (c1 || c2) |-> PRDATA[7:6] == 2'h0;
  endproperty
  property p_off;
    s_off1 |-> ##2 !UNIT_OUT[0];
  endproperty
  property p_flag;
    $fell(UNIT_EVENT_FLAG[0]) |-> $past(acc && PWRITE && PADDR == 8'h30 && PWDATA[0]);
  endproperty
  property p_trig;
    WIDE_TIMER_CLEAR |-> UNIT_EVENT_FLAG != 2'h0;
  endproperty
  property p_adc;
    ADC_START |-> WIDE_TIMER_CLEAR && $past(ADC_ENABLE);
  endproperty
  property p_per;
    PERIOD_TIMER_CLEAR |-> PERIOD_INCREMENT && PERIOD_TIMER_COUNT == PERIOD_VALUE;
  endproperty
  a_rdhi: assert property (p_rdhi)
    else $error("read data upper bits set");
  a_ready: assert property (p_ready)
    else $error("no ready in access");
  a_rsvd: assert property (p_rsvd)
    else $error("control bits 7:6 read set");
  a_off: assert property (p_off)
    else $error("output not low after control cleared");
  a_flag: assert property (p_flag)
    else $error("flag fell without software clear");
  a_trig: assert property (p_trig)
    else $error("trigger without flag");
  a_adc: assert property (p_adc)
    else $error("conversion start without trigger or enable");
  a_per: assert property (p_per)
    else $error("period clear without period end");
  c_clr: cover property (s_clr1);
endmodule // ccpu_props
`default_nettype wire

/* File: test/ccpu_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module ccpu_tb_top
  import ccpu_pkg::*;
;
  logic SYS_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, ADC_ENABLE = 1'b0;
  logic PERIOD_INCREMENT = 1'b0, pwm_run = 1'b0, rerr;
  logic [7:0] PADDR = 8'h00, PERIOD_TIMER_COUNT = 8'h00, PERIOD_VALUE = 8'h03, rdat;
  logic [31:0] PWDATA = 32'h0;
  logic [15:0] WIDE_TIMER_COUNT = 16'h0, q, v;
  logic [1:0] PERIOD_PHASE = 2'h0;
  wire logic PREADY, PSLVERR, WIDE_TIMER_CLEAR, ADC_START, PERIOD_TIMER_CLEAR;
  wire logic [31:0] PRDATA;
  wire logic [1:0] UNIT_PIN, UNIT_OUT, UNIT_EVENT_FLAG;
  int n_mismatch = 0, check_count = 0, n_trig = 0, n_adc = 0, n_hi = 0, n;
  initial forever #5 SYS_CLK = ~SYS_CLK;
  ccpu_top i_ccpu_top (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA),
    .PSLVERR(PSLVERR), .WIDE_TIMER_COUNT(WIDE_TIMER_COUNT), .WIDE_TIMER_CLEAR(WIDE_TIMER_CLEAR),
    .ADC_ENABLE(ADC_ENABLE), .ADC_START(ADC_START), .PERIOD_TIMER_COUNT(PERIOD_TIMER_COUNT),
    .PERIOD_VALUE(PERIOD_VALUE), .PERIOD_INCREMENT(PERIOD_INCREMENT),
    .PERIOD_PHASE(PERIOD_PHASE), .PERIOD_TIMER_CLEAR(PERIOD_TIMER_CLEAR),
    .UNIT_PIN(UNIT_PIN), .UNIT_OUT(UNIT_OUT), .UNIT_EVENT_FLAG(UNIT_EVENT_FLAG));
  ccpu_pin_src i_ccpu_pin_src (.clk(SYS_CLK), .pin(UNIT_PIN));
  // period timer with phase bits; wide timer stays in this clock domain
  always @(posedge SYS_CLK)
  begin
    n_trig <= n_trig + int'(WIDE_TIMER_CLEAR);
    n_adc <= n_adc + int'(ADC_START);
    n_hi <= n_hi + int'(UNIT_OUT[0]);
    if (pwm_run)
    begin
      PERIOD_PHASE <= PERIOD_PHASE + 2'h1;
      PERIOD_INCREMENT <= PERIOD_PHASE == 2'h2;
      if (PERIOD_INCREMENT)
        PERIOD_TIMER_COUNT <= (PERIOD_TIMER_COUNT == PERIOD_VALUE) ? 8'h00 : PERIOD_TIMER_COUNT + 8'h01;
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    PADDR <= a;
    PWDATA <= {24'h0, d};
    PWRITE <= w;
    PSEL <= 1'b1;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    rdat = PRDATA[7:0];
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // one idle cycle so a following call never re-drives psel in the same step
    @(posedge SYS_CLK);
  endtask
  task automatic rdv(input logic [7:0] a);
    xfer(1'b0, a + 8'h04, 8'h00);
    q[15:8] = rdat;
    xfer(1'b0, a, 8'h00);
    q[7:0] = rdat;
  endtask
  task automatic hit(input logic [15:0] h);
    WIDE_TIMER_COUNT <= h;
    @(posedge SYS_CLK);
    WIDE_TIMER_COUNT <= h + 16'h1;
    repeat (3) @(posedge SYS_CLK);
  endtask
  task automatic t_regs;
    logic [7:0] ra [6] = '{8'h54, 8'h58, 8'h5c, 8'h6c, 8'h70, 8'h74};
    foreach (ra[i])
    begin
      xfer(1'b0, ra[i], 8'h00);
      chk(rdat, 16'h0);
    end
    xfer(1'b1, 8'h5c, 8'hf0);
    xfer(1'b0, 8'h5c, 8'h00);
    chk(rdat, 16'h30);
    xfer(1'b1, 8'h54, 8'ha5);
    xfer(1'b1, 8'h58, 8'h5a);
    rdv(8'h54);
    chk(q, 16'h5aa5);
    xfer(1'b0, 8'h04, 8'h00);
    chk(rerr, 1'b1);
  endtask
  task automatic t_cap;
    for (int m = 1; m < 8; m++)
    begin
      n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
      xfer(1'b1, 8'h5c, 8'h00);
      xfer(1'b1, 8'h5c, 8'(m));
      xfer(1'b1, 8'h30, 8'h01);
      v = {4'(m), 12'habc};
      WIDE_TIMER_COUNT <= v;
      i_ccpu_pin_src.edges(0, n - 1);
      chk(UNIT_EVENT_FLAG[0], 1'b0);
      i_ccpu_pin_src.edges(0, 1);
      chk(UNIT_EVENT_FLAG[0], m > 3);
      if (m > 3)
      begin
        rdv(8'h54);
        chk(q, v);
        WIDE_TIMER_COUNT <= ~v;
        i_ccpu_pin_src.edges(0, n);
        rdv(8'h54);
        chk(q, ~v);
      end
    end
  endtask
  task automatic t_cmp;
    logic [7:0] cm [3] = '{8'h08, 8'h0a, 8'h09};
    xfer(1'b1, 8'h54, 8'h34);
    xfer(1'b1, 8'h58, 8'h12);
    WIDE_TIMER_COUNT <= 16'h0;
    foreach (cm[i])
    begin
      xfer(1'b1, 8'h30, 8'h01);
      xfer(1'b1, 8'h5c, cm[i]);
      hit(16'h1234);
      chk(UNIT_OUT[0], i < 2);
      chk(UNIT_EVENT_FLAG[0], 1'b1);
    end
    xfer(1'b1, 8'h5c, 8'h08);
    hit(16'h1234);
    xfer(1'b1, 8'h5c, 8'h00);
    repeat (2) @(posedge SYS_CLK);
    chk(UNIT_OUT[0], 1'b0);
    xfer(1'b1, 8'h6c, 8'h34);
    xfer(1'b1, 8'h70, 8'h12);
    xfer(1'b1, 8'h74, 8'h0b);
    ADC_ENABLE <= 1'b1;
    hit(16'h1234);
    ADC_ENABLE <= 1'b0;
    hit(16'h1234);
    chk(16'(n_trig), 16'h2);
    chk(16'(n_adc), 16'h1);
    chk(UNIT_EVENT_FLAG[1], 1'b1);
    chk(UNIT_OUT[1], 1'b0);
  endtask
  task automatic t_pwm;
    xfer(1'b1, 8'h54, 8'h02);
    xfer(1'b1, 8'h5c, 8'h0c);
    pwm_run <= 1'b1;
    repeat (40) @(posedge SYS_CLK);
    rdv(8'h54);
    chk(q, 16'h0202);
    n = n_hi;
    repeat (32) @(posedge SYS_CLK);
    chk(16'(n_hi - n > 0 && n_hi - n < 32), 16'h1);
    xfer(1'b1, 8'h54, 8'h00);
    repeat (40) @(posedge SYS_CLK);
    n = n_hi;
    repeat (32) @(posedge SYS_CLK);
    chk(16'(n_hi - n), 16'h0);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    @(posedge SYS_CLK);
    t_regs;
    t_cap;
    t_cmp;
    t_pwm;
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge SYS_CLK);
    n_mismatch++;
    give_verdict;
  end
endmodule // ccpu_tb_top
bind ccpu_top ccpu_props i_ccpu_props (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PRDATA(PRDATA), .WIDE_TIMER_CLEAR(WIDE_TIMER_CLEAR), .ADC_ENABLE(ADC_ENABLE),
  .ADC_START(ADC_START), .PERIOD_TIMER_COUNT(PERIOD_TIMER_COUNT), .PERIOD_VALUE(PERIOD_VALUE),
  .PERIOD_INCREMENT(PERIOD_INCREMENT), .PERIOD_TIMER_CLEAR(PERIOD_TIMER_CLEAR),
  .UNIT_OUT(UNIT_OUT), .UNIT_EVENT_FLAG(UNIT_EVENT_FLAG));
`default_nettype wire
